//--- rtl/bos_exec.sv
/*
  Execution of single-bit clear, set and test-skip-if-clear instructions.
  Assumes the register file answers a read address combinationally on
  RD_DATA, accepts a write on the clock edge where WR_EN is high, and that
  the fetch pipeline presents one instruction per cycle while INSN_VALID.
*/
// Summary of operation
// RULE_01 - Every bit instruction carries a 7-bit register address 0..127 and a 3-bit bit number 0..7.
// RULE_02 - Test-skip-if-clear skips the next instruction when the selected bit reads zero, else continues.
// RULE_03 - On a taken skip the prefetched instruction is dropped and has no architectural effect.
// RULE_04 - A taken skip runs a no-operation cycle in its place, so the test takes two cycles.
// RULE_05 - Words beginning 01 are bit operations with op in 11:10, bit in 9:7, address in 6:0; no flags change.
`include "bos_cfg.svh"

module bos_exec (
  input  wire logic        CLK,
  input  wire logic        SRST,
  input  wire logic        INSN_VALID,
  input  wire logic [13:0] INSN,
  output logic      [6:0]  RD_ADR,
  input  wire logic [7:0]  RD_DATA,
  output logic             WR_EN,
  output logic      [6:0]  WR_ADR,
  output logic      [7:0]  WR_DATA,
  output logic             NOP_CYCLE,
  output logic             SKIP_TAKEN,
  output logic             INSN_DONE
);

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  bos_pkg::bos_kind_e kind;
  logic [2:0]         bit_num;
  logic [6:0]         reg_adr;

  bos_decode u_decode (
    .insn    (INSN),
    .kind    (kind),
    .bit_num (bit_num),
    .reg_adr (reg_adr)
  );

  // ----------------------------------------------------------------------
  // Field widths
  // ----------------------------------------------------------------------
  // Internal widths follow the field layout of the header.
  localparam int ADR_W  = `BOS_ADR_HI - `BOS_ADR_LO + 1;
  localparam int BIT_W  = `BOS_BIT_HI - `BOS_BIT_LO + 1;
  localparam int DATA_W = 1 << BIT_W;

  // ----------------------------------------------------------------------
  // Bit arithmetic
  // ----------------------------------------------------------------------
  function automatic logic [7:0] bos_mask(input logic [2:0] b);
    bos_mask = 8'h01 << b;
  endfunction

  function automatic logic [7:0] bos_clear_bit(input logic [7:0] d,
                                               input logic [2:0] b);
    bos_clear_bit = d & ~bos_mask(b);
  endfunction

  function automatic logic [7:0] bos_set_bit(input logic [7:0] d,
                                             input logic [2:0] b);
    bos_set_bit = d | bos_mask(b);
  endfunction

  function automatic logic bos_bit_zero(input logic [7:0] d,
                                        input logic [2:0] b);
    bos_bit_zero = (d & bos_mask(b)) == 8'h00;
  endfunction

  function automatic logic bos_writes(input bos_pkg::bos_kind_e k);
    case (k)
      bos_pkg::BOS_CLEAR: bos_writes = 1'b1;
      bos_pkg::BOS_SET:   bos_writes = 1'b1;
      default:            bos_writes = 1'b0;
    endcase
  endfunction

  function automatic logic bos_tests(input bos_pkg::bos_kind_e k);
    case (k)
      bos_pkg::BOS_TSTCLR: bos_tests = 1'b1;
      default:             bos_tests = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Word qualification
  // ----------------------------------------------------------------------
  logic skip_pend;
  logic drop;
  logic live;

  // A word that meets a pending skip is the prefetched one: it retires as a
  // no-operation and never reaches the register file.
  assign drop = INSN_VALID && skip_pend; // RULE_03
  assign live = INSN_VALID && !skip_pend;

  // Read address follows the word on INSN every cycle, live or not, so the bit is seen in the same cycle;
  // the register file must answer combinationally for this to hold.
  assign RD_ADR = reg_adr; // RULE_01

  // ----------------------------------------------------------------------
  // Skip tracking
  // ----------------------------------------------------------------------
  logic next_skip_pend;
  logic skip_taken;
  logic next_skip_taken;
  logic nop_cycle;
  logic next_nop_cycle;

  // A pending skip waits through invalid cycles; the next valid word is
  // consumed by it whatever that word decodes to.
  always_comb begin
    next_skip_pend  = skip_pend;
    next_skip_taken = 1'b0;
    next_nop_cycle  = 1'b0;
    if (drop) begin
      next_skip_pend = 1'b0; // RULE_03
      next_nop_cycle = 1'b1; // RULE_04
    end else if (live && bos_tests(kind)) begin
      if (bos_bit_zero(RD_DATA, bit_num)) begin
        next_skip_pend  = 1'b1; // RULE_02
        next_skip_taken = 1'b1; // RULE_02
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      skip_pend  <= 1'b0;
      skip_taken <= 1'b0;
      nop_cycle  <= 1'b0;
    end else begin
      skip_pend  <= next_skip_pend;
      skip_taken <= next_skip_taken;
      nop_cycle  <= next_nop_cycle;
    end
  end

  // ----------------------------------------------------------------------
  // Write port
  // ----------------------------------------------------------------------
  logic              wr_en;
  logic              next_wr_en;
  logic [ADR_W-1:0]  wr_adr;
  logic [ADR_W-1:0]  next_wr_adr;
  logic [DATA_W-1:0] wr_data;
  logic [DATA_W-1:0] next_wr_data;

  // Address and data hold their last values between writes, so a watcher of
  // the port sees them move only with a strobe or when SRST loads their reset values.
  always_comb begin
    next_wr_en   = 1'b0;
    next_wr_adr  = wr_adr;
    next_wr_data = wr_data;
    if (live && bos_writes(kind)) begin
      next_wr_en  = 1'b1;
      next_wr_adr = reg_adr; // RULE_01
      case (kind) // RULE_05
        bos_pkg::BOS_SET: begin
          next_wr_data = bos_set_bit(RD_DATA, bit_num);
        end
        bos_pkg::BOS_CLEAR: begin
          next_wr_data = bos_clear_bit(RD_DATA, bit_num);
        end
        default: begin
          next_wr_data = wr_data;
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      wr_en   <= 1'b0;
      wr_adr  <= `BOS_ADR_RST;
      wr_data <= `BOS_DATA_RST;
    end else begin
      wr_en   <= next_wr_en;
      wr_adr  <= next_wr_adr;
      wr_data <= next_wr_data;
    end
  end

  // ----------------------------------------------------------------------
  // Retire
  // ----------------------------------------------------------------------
  logic done;
  logic next_done;

  // The dropped word retires too, so the pipeline counts two cycles for a
  // taken test.
  always_comb begin
    next_done = INSN_VALID; // RULE_04
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      done <= 1'b0;
    end else begin
      done <= next_done;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Writes land one cycle after the word; a read-modify-write of the same
  // register by the very next word would see stale data, so the register
  // file is expected to forward its pending write.
  assign WR_EN      = wr_en;
  assign WR_ADR     = wr_adr;
  assign WR_DATA    = wr_data;
  assign NOP_CYCLE  = nop_cycle;
  assign SKIP_TAKEN = skip_taken;
  assign INSN_DONE  = done;

endmodule

//--- rtl/bos_cfg.svh
/*
  Constants of the bit-operation execution block: instruction field positions,
  operation codes and reset values.
  Assumes inclusion by bare name from the design files.
*/
`ifndef BOS_CFG_SVH
`define BOS_CFG_SVH

`define BOS_INSN_W      14
`define BOS_GRP_HI      13
`define BOS_GRP_LO      12
`define BOS_GRP_BIT     2'h1
`define BOS_OP_HI       11
`define BOS_OP_LO       10
`define BOS_BIT_HI      9
`define BOS_BIT_LO      7
`define BOS_ADR_HI      6
`define BOS_ADR_LO      0
`define BOS_OP_CLEAR    2'h0
`define BOS_OP_SET      2'h1
`define BOS_OP_TSTCLR   2'h2
`define BOS_ADR_RST     7'h00
`define BOS_DATA_RST    8'h00

`endif

//--- rtl/bos_pkg.sv
/*
  Types shared by the bit-operation execution block.
  Assumes nothing of its surroundings.
*/
package bos_pkg;
  typedef enum logic [1:0] {
    BOS_NONE,
    BOS_CLEAR,
    BOS_SET,
    BOS_TSTCLR
  } bos_kind_e;
endpackage

//--- rtl/bos_decode.sv
/*
  Combinational decoder of one instruction word into bit-operation kind,
  bit number and register address.
  Assumes a 14-bit instruction word held stable by the fetch pipeline.
*/
`include "bos_cfg.svh"

module bos_decode (
  input  wire logic [13:0]       insn,
  output bos_pkg::bos_kind_e     kind,
  output logic      [2:0]        bit_num,
  output logic      [6:0]        reg_adr
);

  always_comb begin
    bit_num = insn[`BOS_BIT_HI:`BOS_BIT_LO];
    reg_adr = insn[`BOS_ADR_HI:`BOS_ADR_LO];
    kind    = bos_pkg::BOS_NONE;
    if (insn[`BOS_GRP_HI:`BOS_GRP_LO] == `BOS_GRP_BIT) begin
      case (insn[`BOS_OP_HI:`BOS_OP_LO])
        `BOS_OP_CLEAR:  kind = bos_pkg::BOS_CLEAR;
        `BOS_OP_SET:    kind = bos_pkg::BOS_SET;
        `BOS_OP_TSTCLR: kind = bos_pkg::BOS_TSTCLR;
        default:        kind = bos_pkg::BOS_NONE;
      endcase
    end
  end

endmodule

//--- verif/bos_exec_props.sv
/* Port checker of the bit-operation executor.
   Assumes a bind to bos_exec and a register file that reads combinationally. */
module bos_exec_props (
  input wire logic        CLK,
  input wire logic        SRST,
  input wire logic        INSN_VALID,
  input wire logic [13:0] INSN,
  input wire logic [6:0]  RD_ADR,
  input wire logic [7:0]  RD_DATA,
  input wire logic        WR_EN,
  input wire logic [6:0]  WR_ADR,
  input wire logic [7:0]  WR_DATA,
  input wire logic        NOP_CYCLE,
  input wire logic        SKIP_TAKEN,
  input wire logic        INSN_DONE
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       pend;
  logic       take;
  logic [1:0] op;
  logic       bval;
  assign take = INSN_VALID && !SRST;
  assign op   = INSN[13:12] == 2'h1 ? INSN[11:10] : 2'h3;
  assign bval = RD_DATA[INSN[9:7]];
  // A skip stays pending across idle cycles until a valid word arrives.
  always_ff @(posedge CLK) pend <= SRST ? 1'b0 : take ? (!pend && op == 2'h2 && !bval) : pend;
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  a_rd_follow: assert property (RD_ADR == INSN[6:0])
    else $error("read address wrong");
  a_set_write: assert property (take && !pend && op == 2'h1 |=> WR_EN && WR_ADR == $past(INSN[6:0])
    && WR_DATA == ($past(RD_DATA) | (8'h01 << $past(INSN[9:7])))) else $error("set wrong");
  a_clr_write: assert property (take && !pend && op == 2'h0 |=> WR_EN && WR_ADR == $past(INSN[6:0])
    && WR_DATA == ($past(RD_DATA) & ~(8'h01 << $past(INSN[9:7])))) else $error("clear wrong");
  a_skip_zero: assert property (take && !pend && op == 2'h2 |=> SKIP_TAKEN == !$past(bval) && !WR_EN)
    else $error("skip wrong");
  a_drop_word: assert property (take && pend |=> NOP_CYCLE && !WR_EN && !SKIP_TAKEN)
    else $error("drop wrong");
  a_nop_cause: assert property (!(take && pend) |=> !NOP_CYCLE)
    else $error("stray no-op");
  a_done_word: assert property (1'b1 |=> INSN_DONE == $past(take))
    else $error("done wrong");
endmodule

//--- verif/bos_regfile.sv
/* Data register file model on the far side of the executor.
   Assumes one write port on the rising edge and a combinational read. */
module bos_regfile (
  input wire logic       clk,
  input wire logic [6:0] rd_adr,
  output logic     [7:0] rd_data,
  input wire logic       wr_en,
  input wire logic [6:0] wr_adr,
  input wire logic [7:0] wr_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [128];
  initial for (int i = 0; i < 128; i++) mem[i] = 8'(i) ^ 8'h5a;
  // The write in flight is forwarded, so the very next word reads its result.
  assign rd_data = (wr_en && wr_adr == rd_adr) ? wr_data : mem[rd_adr];
  always @(posedge clk) if (wr_en) mem[wr_adr] <= wr_data;
endmodule

//--- verif/tb_bos_exec.sv
/* Testbench of the bit-operation executor.
   Assumes the register file model and the port checker. */
module tb_bos_exec;
  timeunit 1ns;
  timeprecision 1ps;
  logic        CLK = 0, SRST = 1, INSN_VALID = 0, WR_EN, NOP_CYCLE, SKIP_TAKEN, INSN_DONE;
  logic [13:0] INSN = 14'h0000;
  logic [6:0]  RD_ADR, WR_ADR, a;
  logic [7:0]  RD_DATA, WR_DATA, old;
  int          bad_count = 0, checked = 0;
  bos_exec DUT (
    .CLK        (CLK),
    .SRST       (SRST),
    .INSN_VALID (INSN_VALID),
    .INSN       (INSN),
    .RD_ADR     (RD_ADR),
    .RD_DATA    (RD_DATA),
    .WR_EN      (WR_EN),
    .WR_ADR     (WR_ADR),
    .WR_DATA    (WR_DATA),
    .NOP_CYCLE  (NOP_CYCLE),
    .SKIP_TAKEN (SKIP_TAKEN),
    .INSN_DONE  (INSN_DONE)
  );
  bos_regfile RF (.clk(CLK), .rd_adr(RD_ADR), .rd_data(RD_DATA), .wr_en(WR_EN), .wr_adr(WR_ADR), .wr_data(WR_DATA));
  initial forever #2.5 CLK = ~CLK;
  task chk(input logic [7:0] g, e);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %0t got %h want %h", $time, g, e);
    end
  endtask
  task fl(input logic [3:0] e);
    chk({4'h0, WR_EN, SKIP_TAKEN, NOP_CYCLE, INSN_DONE}, {4'h0, e});
  endtask
  task step(input logic [13:0] w, input logic v);
    @(negedge CLK);
    INSN = w;
    INSN_VALID = v;
    @(posedge CLK);
    #1;
  endtask
  task t_set_clear;
    for (int k = 0; k < 8; k++) begin
      a = k[0] ? 7'h7f : 7'h00;
      old = RF.mem[a];
      step({3'h2, k[2], k[1] ? 3'h7 : 3'h0, a}, 1'b1);
      fl(4'h9);
      chk({1'b0, WR_ADR}, {1'b0, a});
      chk(WR_DATA, k[2] ? old | (8'h01 << (k[1] * 7)) : old & ~(8'h01 << (k[1] * 7)));
    end
  endtask
  task t_skip_drop;
    step({4'h4, 3'h2, 7'h09}, 1'b1);
    step({4'h6, 3'h2, 7'h09}, 1'b1);
    fl(4'h5);
    step({4'h5, 3'h2, 7'h09}, 1'b1);
    fl(4'h3);
    step({4'h6, 3'h2, 7'h09}, 1'b1);
    fl(4'h5);
    step(14'h0000, 1'b0);
    fl(4'h0);
    step({4'h7, 3'h2, 7'h09}, 1'b1);
    fl(4'h3);
    step({4'h5, 3'h2, 7'h09}, 1'b1);
    step({4'h6, 3'h2, 7'h09}, 1'b1);
    fl(4'h1);
    step({4'h7, 3'h2, 7'h09}, 1'b1);
    fl(4'h1);
    step(14'h2089, 1'b1);
    fl(4'h1);
  endtask
  task t_reset_pend;
    step({4'h6, 3'h3, 7'h09}, 1'b1);
    fl(4'h5);
    @(negedge CLK);
    SRST = 1'b1;
    INSN_VALID = 1'b0;
    @(posedge CLK);
    #1;
    fl(4'h0);
    @(negedge CLK);
    SRST = 1'b0;
    step({4'h5, 3'h3, 7'h09}, 1'b1);
    fl(4'h9);
    chk(WR_DATA, 8'h5f);
    chk({1'b0, RD_ADR}, 8'h09);
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge CLK);
    SRST = 0;
    t_set_clear;
    t_skip_drop;
    t_reset_pend;
    give_verdict;
  end
  initial begin
    #2000;
    bad_count++;
    give_verdict;
  end
endmodule
bind bos_exec bos_exec_props chk_i (
  .CLK        (CLK),
  .SRST       (SRST),
  .INSN_VALID (INSN_VALID),
  .INSN       (INSN),
  .RD_ADR     (RD_ADR),
  .RD_DATA    (RD_DATA),
  .WR_EN      (WR_EN),
  .WR_ADR     (WR_ADR),
  .WR_DATA    (WR_DATA),
  .NOP_CYCLE  (NOP_CYCLE),
  .SKIP_TAKEN (SKIP_TAKEN),
  .INSN_DONE  (INSN_DONE)
);
